// ===== src/spm_status_mask.v
// Status pin event mask registers and active-low status pin driver
// What this block does
// RULE1 - Mask bit 0 blocks its latched flag from the pin; 1 lets it through.
// RULE2 - Undervoltage mask at 0x2064: bits 14..0, all reset to one.
// RULE3 - Undervoltage mask bits 31..15 are reserved and read zero.
// RULE4 - Overvoltage mask at 0x2068: bits 13..0 reset one, upper bits zero.
// RULE5 - Warning mask at 0x206C: same layout as overvoltage, gates warnings.
// RULE6 - Overtemperature mask at 0x2070: bits 11..0 reset one, rest zero.
// RULE7 - Misc mask bits 28..25 gate external and detection events, reset 0.
// RULE8 - Misc mask bits 24..19 gate sync to shadow ECC failures, reset one.
// RULE9 - Misc bits 18..16 gate pin external failures, reset 0; gaps read 0.
// RULE10 - Misc bits 8..0 gate serial and watchdog failures, reset one.
// RULE11 - Pin low one clock after any flag and its mask are both set; flags untouched.
// RULE12 - Writes into reserved positions are ignored without side effect.
`timescale 1ns/1ns
`include "spm_consts.vh"

module spm_status_mask (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        reg_wr_en,
	input  wire        reg_rd_en,
	input  wire [15:0] reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	output reg         reg_addr_hit,
	input  wire [14:0] uv_flags,
	input  wire [13:0] ov_flags,
	input  wire [13:0] warn_flags,
	input  wire [11:0] ot_flags,
	input  wire [28:0] misc_flags,
	output reg         status_pin_n,
	output wire [31:0] uv_mask,
	output wire [31:0] ov_mask,
	output wire [31:0] warn_mask,
	output wire [31:0] ot_mask,
	output wire [31:0] misc_mask
);

	reg  [31:0] mask_r [0:`SPM_REG_COUNT-1];
	reg  [31:0] rdata_nxt;
	reg         hit_nxt;
	reg  [31:0] wdata_sel;
	wire [31:0] flag_vec [0:`SPM_REG_COUNT-1];
	wire [`SPM_REG_COUNT-1:0] grp_active;
	wire        any_active;

	// Decoder shared by the read path and the write path
	function [2:0] spm_index;
		input [15:0] a;
		begin
			if (a == `SPM_UV_OFFSET)
				spm_index = 3'h0;
			else if (a == `SPM_OV_OFFSET)
				spm_index = 3'h1;
			else if (a == `SPM_WARN_OFFSET)
				spm_index = 3'h2;
			else if (a == `SPM_OT_OFFSET)
				spm_index = 3'h3;
			else if (a == `SPM_MISC_OFFSET)
				spm_index = 3'h4;
			else
				spm_index = 3'h7;
		end
	endfunction

	function [31:0] spm_wmask;
		input [2:0] i;
		begin
			case (i)
			3'h0: spm_wmask = `SPM_UV_WMASK;
			3'h1: spm_wmask = `SPM_OV_WMASK;
			3'h2: spm_wmask = `SPM_WARN_WMASK;
			3'h3: spm_wmask = `SPM_OT_WMASK;
			3'h4: spm_wmask = `SPM_MISC_WMASK;
			default: spm_wmask = 32'h00000000;
			endcase
		end
	endfunction

	function [31:0] spm_rstval;
		input [2:0] i;
		begin
			case (i)
			3'h0: spm_rstval = `SPM_UV_RESET;
			3'h1: spm_rstval = `SPM_OV_RESET;
			3'h2: spm_rstval = `SPM_WARN_RESET;
			3'h3: spm_rstval = `SPM_OT_RESET;
			3'h4: spm_rstval = `SPM_MISC_RESET;
			default: spm_rstval = 32'h00000000;
			endcase
		end
	endfunction

	// Flag vectors placed at the same bit positions as their masks
	assign flag_vec[0] = {17'h00000, uv_flags};
	assign flag_vec[1] = {18'h00000, ov_flags};
	assign flag_vec[2] = {18'h00000, warn_flags};
	assign flag_vec[3] = {20'h00000, ot_flags};
	assign flag_vec[4] = {3'h0, misc_flags};

	genvar g;
	generate
		for (g = 0; g < `SPM_REG_COUNT; g = g + 1) begin : g_bank
			// RULE2 RULE4 RULE5 reset and write
			always @(posedge clk) begin
				if (!rst_n) begin
					// RULE6 RULE7 RULE8 RULE9 RULE10 reset
					mask_r[g] <= spm_rstval(g);
				end else if (reg_wr_en &&
					spm_index(reg_addr) == g) begin
					// RULE12 reserved writes dropped
					mask_r[g] <= reg_wdata & spm_wmask(g);
				end
			end
			// RULE1 mask gating
			assign grp_active[g] = |(flag_vec[g] & mask_r[g]);
		end
	endgenerate

	assign uv_mask   = mask_r[0];
	assign ov_mask   = mask_r[1];
	assign warn_mask = mask_r[2];
	assign ot_mask   = mask_r[3];
	assign misc_mask = mask_r[4];

	// RULE11 any unmasked flag
	assign any_active = |grp_active;

	// Registered so the pin never glitches on decode hazards
	always @(posedge clk) begin
		if (!rst_n)
			status_pin_n <= 1'b1;
		else
			status_pin_n <= ~any_active;
	end

	// RULE3 reserved bits read zero
	always @* begin
		wdata_sel = 32'h00000000;
		hit_nxt   = 1'b0;
		if (spm_index(reg_addr) != 3'h7) begin
			wdata_sel = mask_r[spm_index(reg_addr)];
			hit_nxt   = 1'b1;
		end
		rdata_nxt = wdata_sel & spm_wmask(spm_index(reg_addr));
	end

	// Unmapped reads return zero with the hit flag low
	always @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata    <= 32'h00000000;
			reg_addr_hit <= 1'b0;
		end else if (reg_rd_en) begin
			reg_rdata    <= rdata_nxt;
			reg_addr_hit <= hit_nxt;
		end
	end

endmodule

// ===== src/spm_consts.vh
// Offsets, field layouts and reset values of the status-pin mask bank
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH

`define SPM_ADDR_W        16
`define SPM_UV_OFFSET     16'h2064
`define SPM_OV_OFFSET     16'h2068
`define SPM_WARN_OFFSET   16'h206C
`define SPM_OT_OFFSET     16'h2070
`define SPM_MISC_OFFSET   16'h2074

`define SPM_UV_WIDTH      15
`define SPM_OV_WIDTH      14
`define SPM_WARN_WIDTH    14
`define SPM_OT_WIDTH      12
`define SPM_MISC_WIDTH    29

`define SPM_UV_WMASK      32'h00007FFF
`define SPM_OV_WMASK      32'h00003FFF
`define SPM_WARN_WMASK    32'h00003FFF
`define SPM_OT_WMASK      32'h00000FFF
`define SPM_MISC_WMASK    32'h1FFF01FF

`define SPM_UV_RESET      32'h00007FFF
`define SPM_OV_RESET      32'h00003FFF
`define SPM_WARN_RESET    32'h00003FFF
`define SPM_OT_RESET      32'h00000FFF
`define SPM_MISC_RESET    32'h01F801FF

`define SPM_REG_COUNT     5

`endif

// ===== verification/spm_host.sv
// Host model that samples the status pin
`timescale 1ns/1ns
module spm_host (
	input  wire clk,
	input  wire pin_n,
	output reg  low_r);
	always @(posedge clk) low_r <= !pin_n;
endmodule

// ===== verification/spm_status_mask_sva.sv
// Port checks for the status mask bank
`timescale 1ns/1ns
module spm_sva (
	input wire        clk,
	input wire        rst_n,
	input wire        reg_wr_en,
	input wire [15:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [14:0] uv_flags,
	input wire        status_pin_n,
	input wire [31:0] uv_mask,
	input wire [31:0] ov_mask,
	input wire [31:0] misc_mask);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire wu = reg_wr_en && reg_addr == 16'h2064;
	wire wm = reg_wr_en && reg_addr == 16'h2074;
	property p_lo; |(uv_flags & uv_mask[14:0]) |=> !status_pin_n; endproperty
	a_lo: assert property (p_lo) else $error("pin high");
	property p_ur; ~|uv_mask[31:15]; endproperty
	a_ur: assert property (p_ur) else $error("uv rsv");
	property p_or; ~|ov_mask[31:14]; endproperty
	a_or: assert property (p_or) else $error("ov rsv");
	property p_mr; ~|{misc_mask[31:29], misc_mask[15:9]}; endproperty
	a_mr: assert property (p_mr) else $error("misc rsv");
	property p_uw; wu |=> uv_mask == ($past(reg_wdata) & 32'h7FFF); endproperty
	a_uw: assert property (p_uw) else $error("uv write");
	property p_us; !wu |=> $stable(uv_mask); endproperty
	a_us: assert property (p_us) else $error("uv moved");
	property p_mw;
		wm |=> misc_mask == ($past(reg_wdata) & 32'h1FFF01FF);
	endproperty
	a_mw: assert property (p_mw) else $error("misc write");
	property p_ms; !wm |=> $stable(misc_mask); endproperty
	a_ms: assert property (p_ms) else $error("misc moved");
endmodule
bind spm_status_mask spm_sva u_sva (.clk(clk), .rst_n(rst_n),
	.reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.uv_flags(uv_flags), .status_pin_n(status_pin_n), .uv_mask(uv_mask),
	.ov_mask(ov_mask), .misc_mask(misc_mask));

// ===== verification/spm_status_mask_bench.sv
// Random bench for the status mask bank
`timescale 1ns/1ns
`include "spm_consts.vh"
`define CK(x, y) begin n_tests++; if ((x) !== (y)) begin mismatches++; \
	$display("BAD %0t diff", $time); end end
module spm_status_mask_bench;
	reg         clk = 0, rst_n = 0, we = 0, re = 0, pp = 1;
	reg  [15:0] a = 0, r = 16'hCB99;
	reg  [31:0] d = 0, m [0:4];
	reg  [83:0] f = 0;
	reg [159:0] w = {`SPM_MISC_WMASK, `SPM_OT_WMASK, `SPM_WARN_WMASK,
		`SPM_OV_WMASK, `SPM_UV_WMASK};
	wire [31:0] q, mu, mo, mw, mt, mm;
	wire        hit, pin, low, pe = ~|(f & {m[0][14:0], m[1][13:0], m[2][13:0],
		m[3][11:0], m[4][28:0]});
	integer     mismatches = 0, n_tests = 0, i, k;
	always #25 clk = ~clk;
	spm_status_mask u_dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(we),
		.reg_rd_en(re), .reg_addr(a), .reg_wdata(d), .reg_rdata(q),
		.reg_addr_hit(hit), .uv_flags(f[83:69]), .ov_flags(f[68:55]),
		.warn_flags(f[54:41]), .ot_flags(f[40:29]), .misc_flags(f[28:0]),
		.status_pin_n(pin), .uv_mask(mu), .ov_mask(mo), .warn_mask(mw),
		.ot_mask(mt), .misc_mask(mm));
	spm_host u_host (.clk(clk), .pin_n(pin), .low_r(low));
	function [15:0] nx(input [15:0] s); nx = {s[14:0], s[15]^s[13]^s[12]^s[10]};
	endfunction
	task print_verdict;
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		for (k = 0; k < 5; k++) m[k] = w[k*32 +: 32];
		m[4] = `SPM_MISC_RESET;
		#76 rst_n = 1;
		`CK({pin, hit, q}, {1'h1, 1'h0, 32'h00000000})
		for (i = 0; i < 80; i++) begin
			r = nx(nx(r));
			k = (i < 6) ? i : r % 6;
			a = 16'h2064 + 16'(k * 4);
			d = {r, nx(r)};
			f = r[4] ? 84'h0 : 84'h1 << r[15:9];
			we = i > 5 && i[0];
			re = !we;
			@(posedge clk) #1;
			`CK(pin, pe)
			`CK(low, !pp)
			pp = pe;
			if (we && k < 5) m[k] = d & w[k*32 +: 32];
			else if (re) `CK({hit, q}, {k < 5, k < 5 ? m[k] : 32'h0})
			`CK({mu, mo, mw, mt, mm}, {m[0], m[1], m[2], m[3], m[4]})
		end
		print_verdict;
	end
endmodule
